// ### logic/flash_host_pkg.sv
// Shared constants for the parallel flash host controller.
// Assumes a 100 MHz system clock; all pin timings become cycle counts here.
`default_nettype none
package flash_host_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Pin, counter and sequence widths
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int CNT_W = 12;
    localparam int SEQ_W = 2;
    // Index of the last cycle in each program sequence
    localparam logic [SEQ_W-1:0] SEQ_LEN_STD = 2'h3;
    localparam logic [SEQ_W-1:0] SEQ_LEN_BYPASS = 2'h1;
    // Pin timings in ns; values are plain defaults, not taken from a part
    localparam int T_ACC_NS = 100;
    localparam int T_WP_NS = 50;
    localparam int T_WPH_NS = 30;
    localparam int T_RP_NS = 500;
    localparam int T_READY_NS = 20000;
    // Least times round up, at least one cycle
    localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_CYC = (T_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Synchroniser latency on pins read back
    localparam int SYNC_CYC = 2;
    localparam logic [CNT_W-1:0] RD_WAIT = CNT_W'(ACC_CYC + SYNC_CYC);
    localparam logic [CNT_W-1:0] WP_WAIT = CNT_W'(WP_CYC);
    localparam logic [CNT_W-1:0] WPH_WAIT = CNT_W'(WPH_CYC);
    localparam logic [CNT_W-1:0] RP_WAIT = CNT_W'(RP_CYC);
    localparam logic [CNT_W-1:0] READY_WAIT = CNT_W'(READY_CYC);
    // Reset values
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;
    localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
    // Operations requested by the user side
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_PROGRAM,
        OP_RESET
    } op_t;
endpackage
`default_nettype wire

// ### logic/pin_sync.sv
// Two-flop synchroniser for pins driven by the flash.
// Assumes inputs are asynchronous to clk_sys_i.
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Pin side
    input wire logic [WIDTH-1:0] async_i,
    // Synchronised side
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule
`default_nettype wire

// ### logic/flash_host.sv
// Host-side controller driving a parallel NOR flash through its pins.
// Assumes a user port on clk_sys_i; flash pins are asynchronous to it.
//
// Overview of operation
// - Reads drive select, gate low, write high
// - Writes drive strobe, select low, gate high
// - Bypass program takes two writes, not four
// - Wait access time after leaving standby
// - Reissue operation aborted by reset; code only pulses aborted_o, user reissues
// - Idle reset completes; read after release
`default_nettype none
module flash_host (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // User request
    input wire logic req_i,
    input wire logic [1:0] op_i,
    input wire logic bypass_i,
    input wire logic byte_mode_i,
    input wire logic [20:0] addr_i,
    input wire logic addr_lsb_i,
    input wire logic [15:0] wdata_i,
    // User answer
    output logic busy_o,
    output logic done_o,
    output logic [1:0] seq_idx_o,
    output logic [15:0] rdata_o,
    output logic aborted_o,
    output logic timeout_o,
    output logic ready_busy_o,
    // Flash pins
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic reset_n_o,
    output logic byte_n_o,
    output logic [20:0] addr_o,
    output logic [15:0] dq_o,
    output logic [15:0] dq_oe_o,
    input wire logic [15:0] dq_i,
    input wire logic ready_busy_flag_i
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD,
        ST_RST_PULSE,
        ST_RST_WAIT
    } state_t;

    typedef struct packed {
        state_t state;
        logic [11:0] cnt;
        logic [1:0] idx;
        logic [1:0] last;
        logic [1:0] op;
        logic word_mode;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_n;
        logic [20:0] addr;
        logic lsb;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic done;
        logic aborted;
        logic timeout;
        logic drive;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = '{
        state: ST_IDLE,
        cnt: flash_host_pkg::CNT_RST,
        idx: 2'h0,
        last: 2'h0,
        op: 2'h0,
        word_mode: 1'b1,
        ce_n: 1'b1,
        oe_n: 1'b1,
        we_n: 1'b1,
        reset_n: 1'b1,
        addr: flash_host_pkg::ADDR_RST,
        lsb: 1'b0,
        wdata: flash_host_pkg::DATA_RST,
        rdata: flash_host_pkg::DATA_RST,
        done: 1'b0,
        aborted: 1'b0,
        timeout: 1'b0,
        drive: 1'b0
    };

    ctrl_t ctrl_reg;
    ctrl_t ctrl_next;
    logic [16:0] pins_sync;
    logic [15:0] dq_sync;
    logic rb_sync;

    // Read data and ready flag pass through a two-flop synchroniser from the pins
    pin_sync #(
        .WIDTH(17)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i({ready_busy_flag_i, dq_i}),
        .sync_o(pins_sync)
    );

    assign dq_sync = pins_sync[15:0];
    assign rb_sync = pins_sync[16];

    always_comb begin
        ctrl_next = ctrl_reg;
        ctrl_next.done = 1'b0;
        ctrl_next.aborted = 1'b0;
        if (ctrl_reg.cnt != flash_host_pkg::CNT_RST) begin
            ctrl_next.cnt = ctrl_reg.cnt - 12'h001;
        end
        unique case (ctrl_reg.state)
            ST_IDLE: begin
                // Select high keeps the device in standby, outputs floating
                ctrl_next.ce_n = 1'b1;
                ctrl_next.oe_n = 1'b1;
                ctrl_next.we_n = 1'b1;
                ctrl_next.drive = 1'b0;
                ctrl_next.idx = 2'h0;
                // Width pin only changes between operations
                ctrl_next.word_mode = byte_mode_i ? 1'b0 : 1'b1;
                if (req_i) begin
                    ctrl_next.op = op_i;
                    ctrl_next.addr = addr_i;
                    ctrl_next.lsb = addr_lsb_i;
                    ctrl_next.wdata = wdata_i;
                    ctrl_next.timeout = 1'b0;
                    unique case (flash_host_pkg::op_t'(op_i))
                        flash_host_pkg::OP_READ: begin
                            // Access timed from select, covering standby exit
                            ctrl_next.state = ST_READ;
                            ctrl_next.ce_n = 1'b0;
                            ctrl_next.oe_n = 1'b0;
                            ctrl_next.cnt = flash_host_pkg::RD_WAIT;
                        end
                        flash_host_pkg::OP_WRITE: begin
                            ctrl_next.state = ST_WR_SETUP;
                            ctrl_next.last = 2'h0;
                        end
                        flash_host_pkg::OP_PROGRAM: begin
                            ctrl_next.state = ST_WR_SETUP;
                            ctrl_next.last = bypass_i ? flash_host_pkg::SEQ_LEN_BYPASS
                                : flash_host_pkg::SEQ_LEN_STD;
                        end
                        flash_host_pkg::OP_RESET: begin
                            ctrl_next.state = ST_RST_PULSE;
                            ctrl_next.reset_n = 1'b0;
                            ctrl_next.cnt = flash_host_pkg::RP_WAIT;
                        end
                    endcase
                end
            end
            ST_READ: begin
                // Address held still so a sleeping device keeps data latched
                if (ctrl_reg.cnt == flash_host_pkg::CNT_RST) begin
                    // Byte mode: only the low eight lines carry data
                    ctrl_next.rdata = ctrl_reg.word_mode ? dq_sync
                        : {8'h00, dq_sync[7:0]};
                    ctrl_next.ce_n = 1'b1;
                    ctrl_next.oe_n = 1'b1;
                    ctrl_next.done = 1'b1;
                    ctrl_next.state = ST_IDLE;
                end
            end
            ST_WR_SETUP: begin
                // Gate stays high so a write never collides with read data
                ctrl_next.ce_n = 1'b0;
                ctrl_next.oe_n = 1'b1;
                ctrl_next.drive = 1'b1;
                ctrl_next.we_n = 1'b0;
                ctrl_next.cnt = flash_host_pkg::WP_WAIT;
                ctrl_next.state = ST_WR_PULSE;
            end
            ST_WR_PULSE: begin
                if (ctrl_reg.cnt == flash_host_pkg::CNT_RST) begin
                    // Rising strobe latches data; data held through hold time
                    ctrl_next.we_n = 1'b1;
                    ctrl_next.cnt = flash_host_pkg::WPH_WAIT;
                    ctrl_next.state = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD: begin
                if (ctrl_reg.cnt == flash_host_pkg::CNT_RST) begin
                    ctrl_next.ce_n = 1'b1;
                    ctrl_next.drive = 1'b0;
                    if (ctrl_reg.idx == ctrl_reg.last) begin
                        ctrl_next.done = 1'b1;
                        ctrl_next.state = ST_IDLE;
                    end else begin
                        // Next cycle's address and data come from the user
                        ctrl_next.idx = ctrl_reg.idx + 2'h1;
                        ctrl_next.addr = addr_i;
                        ctrl_next.lsb = addr_lsb_i;
                        ctrl_next.wdata = wdata_i;
                        ctrl_next.state = ST_WR_SETUP;
                    end
                end
            end
            ST_RST_PULSE: begin
                ctrl_next.ce_n = 1'b1;
                ctrl_next.drive = 1'b0;
                if (ctrl_reg.cnt == flash_host_pkg::CNT_RST) begin
                    ctrl_next.reset_n = 1'b1;
                    if (!rb_sync) begin
                        // Busy at reset: the aborted operation must be redone
                        ctrl_next.aborted = 1'b1;
                        ctrl_next.cnt = flash_host_pkg::READY_WAIT;
                        ctrl_next.state = ST_RST_WAIT;
                    end else begin
                        // Idle device may be read right after release
                        ctrl_next.done = 1'b1;
                        ctrl_next.state = ST_IDLE;
                    end
                end
            end
            ST_RST_WAIT: begin
                // Bounded wait so a stuck flag cannot hang the port
                if (rb_sync) begin
                    ctrl_next.done = 1'b1;
                    ctrl_next.state = ST_IDLE;
                end else if (ctrl_reg.cnt == flash_host_pkg::CNT_RST) begin
                    ctrl_next.timeout = 1'b1;
                    ctrl_next.done = 1'b1;
                    ctrl_next.state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // User answer
    assign busy_o = (ctrl_reg.state != ST_IDLE);
    assign done_o = ctrl_reg.done;
    assign seq_idx_o = ctrl_reg.idx;
    assign rdata_o = ctrl_reg.rdata;
    assign aborted_o = ctrl_reg.aborted;
    assign timeout_o = ctrl_reg.timeout;
    assign ready_busy_o = rb_sync;

    // Flash pins
    assign ce_n_o = ctrl_reg.ce_n;
    assign oe_n_o = ctrl_reg.oe_n;
    assign we_n_o = ctrl_reg.we_n;
    assign reset_n_o = ctrl_reg.reset_n;
    assign byte_n_o = ctrl_reg.word_mode;
    assign addr_o = ctrl_reg.addr;

    always_comb begin
        dq_o = ctrl_reg.wdata;
        dq_oe_o = 16'h0000;
        if (ctrl_reg.word_mode) begin
            dq_oe_o = {16{ctrl_reg.drive}};
        end else begin
            // Line fifteen is an address input in byte mode, driven always
            dq_o = {ctrl_reg.lsb, 7'h00, ctrl_reg.wdata[7:0]};
            dq_oe_o = {1'b1, 7'h00, {8{ctrl_reg.drive}}};
        end
    end
endmodule
`default_nettype wire

// ### verif/flash_host_assertions.sv
// Pin protocol checks for flash_host.
// Assumes a bind to flash_host; sees its ports only.
`default_nettype none
module flash_host_checker (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic done_o,
    input wire logic aborted_o,
    input wire logic ce_n_o,
    input wire logic oe_n_o,
    input wire logic we_n_o,
    input wire logic reset_n_o,
    input wire logic byte_n_o,
    input wire logic [15:0] dq_oe_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    AST_RD_PINS: assert property (!oe_n_o |-> !ce_n_o && we_n_o && dq_oe_o[14:0] == 15'h0000)
        else $error("read strobes wrong");
    AST_WR_PINS: assert property (!we_n_o |-> !ce_n_o && oe_n_o && dq_oe_o[7:0] == 8'hff)
        else $error("write strobes wrong");
    AST_WORD_DRIVE: assert property (byte_n_o && !we_n_o |-> dq_oe_o == 16'hffff)
        else $error("word write not on all lines");
    AST_BYTE_HIZ: assert property (!byte_n_o |-> dq_oe_o[14:8] == 7'h00)
        else $error("upper lines driven in byte mode");
    AST_WR_PULSE: assert property ($fell(we_n_o) |-> !we_n_o [*5])
        else $error("write pulse short");
    AST_RST_PULSE: assert property ($fell(reset_n_o) |-> ##50 !reset_n_o)
        else $error("reset pulse short");
    AST_RST_QUIET: assert property (!reset_n_o |-> ce_n_o && we_n_o)
        else $error("access during reset");
    AST_RD_HOLD: assert property ($fell(oe_n_o) |-> !oe_n_o [*8])
        else $error("read ended before access time");
    AST_DONE_END: assert property (done_o |-> ce_n_o && we_n_o ##1 !done_o)
        else $error("done while selected");
    AST_ABORT: assert property (aborted_o |-> reset_n_o && !done_o)
        else $error("abort flag misplaced");
endmodule
`default_nettype wire

// ### verif/flash_dev_model.sv
// Behavioural parallel flash seen at its pins.
// Assumes host pins wired straight in; no timing checks.
`default_nettype none
module flash_dev_model (
    // Strobes
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic reset_n_i,
    input wire logic byte_n_i,
    // From host
    input wire logic [20:0] addr_i,
    input wire logic [15:0] dq_h_i,
    input wire logic [15:0] dq_oe_i,
    // To host
    output logic [15:0] dq_o,
    output logic rb_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;
    logic ident = 1'b0;
    // Arbitrary value, names no real part
    localparam logic [7:0] ID_CODE = 8'h3c;
    logic [15:0] flt = 16'h5a5a;
    logic [15:0] dev;
    logic [15:0] w;
    logic [20:0] last_a;
    logic [15:0] last_d;
    logic lsb;
    int wcnt = 0;
    // Floating lines keep changing, never hold a value
    always #7 flt = ~flt;
    assign lsb = dq_oe_i[15] ? dq_h_i[15] : flt[15];
    assign w = {addr_i[20:16], 11'h000} ^ addr_i[15:0] ^ 16'ha5c3;
    always_comb begin
        dev = flt;
        if (!ce_n_i && !oe_n_i && we_n_i && reset_n_i) begin
            if (busy)
                dev = 16'h0080;
            else if (ident)
                dev[7:0] = ID_CODE;
            else if (byte_n_i)
                dev = w;
            else
                dev[7:0] = lsb ? w[15:8] : w[7:0];
        end
    end
    assign dq_o = (dq_oe_i & dq_h_i) | (~dq_oe_i & dev);
    assign rb_o = ~busy;
    always @(posedge we_n_i) begin
        if (!ce_n_i && oe_n_i && reset_n_i) begin
            wcnt++;
            last_a = addr_i;
            last_d = byte_n_i ? dq_h_i : {8'h00, dq_h_i[7:0]};
        end
    end
    // Deselect leaves a job running; reset ends it after recovery
    always @(negedge reset_n_i) begin
        ident = 1'b0;
        if (busy) begin
            #1000;
            busy = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### verif/tb_flash_host.sv
// Self-checking bench for flash_host with a flash pin model.
// Assumes checker and model compiled first.
`default_nettype none
module tb_flash_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i, rst_i, req_i, bypass_i, byte_mode_i, addr_lsb_i, ab;
    logic [1:0] op_i, seq_idx_o;
    logic [20:0] addr_i, addr_o, a;
    logic [15:0] wdata_i, rdata_o, dq_o, dq_oe_o, dq_i, d;
    logic busy_o, done_o, aborted_o, timeout_o, ready_busy_o, ce_n_o, oe_n_o, we_n_o;
    logic reset_n_o, byte_n_o, ready_busy_flag_i, l, bz;
    logic [1:0] mx;
    int cyc;
    int n_errors = 0;
    int comparisons = 0;
    flash_host dut (.clk_sys_i, .rst_i, .req_i, .op_i, .bypass_i, .byte_mode_i, .addr_i,
        .addr_lsb_i, .wdata_i, .busy_o, .done_o, .seq_idx_o, .rdata_o, .aborted_o, .timeout_o,
        .ready_busy_o, .ce_n_o, .oe_n_o, .we_n_o, .reset_n_o, .byte_n_o, .addr_o, .dq_o,
        .dq_oe_o, .dq_i, .ready_busy_flag_i);
    flash_dev_model m (.ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
        .reset_n_i(reset_n_o), .byte_n_i(byte_n_o), .addr_i(addr_o), .dq_h_i(dq_o),
        .dq_oe_i(dq_oe_o), .dq_o(dq_i), .rb_o(ready_busy_flag_i));
    function automatic logic [20:0] exp_rd(logic [20:0] x, logic bm, logic lo);
        logic [15:0] v;
        v = {x[20:16], 11'h000} ^ x[15:0] ^ 16'ha5c3;
        return 21'(bm ? {8'h00, lo ? v[15:8] : v[7:0]} : v);
    endfunction
    task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic do_op(input logic [1:0] op, input logic [20:0] x, input logic lo,
        input logic bm, input logic byp, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        byte_mode_i <= bm;
        repeat (2) @(posedge clk_sys_i);
        {op_i, addr_i, addr_lsb_i, bypass_i, wdata_i, req_i} <= {op, x, lo, byp, wd, 1'b1};
        @(posedge clk_sys_i);
        req_i <= 1'b0;
        ab = 1'b0;
        bz = 1'b1;
        mx = 2'h0;
        @(negedge clk_sys_i);
        while (done_o !== 1'b1 && n < 5000) begin
            ab = ab | aborted_o;
            bz = bz & busy_o;
            if (seq_idx_o > mx)
                mx = seq_idx_o;
            @(negedge clk_sys_i);
            n++;
        end
        cyc = n;
        chk(21'(bz), 21'h1);
        if (n >= 5000) begin
            n_errors++;
            $display("unexpected at %0t: operation never finished", $time);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Whole run needs about 500 cycles
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
    initial begin
        {req_i, op_i, bypass_i, byte_mode_i, addr_i, addr_lsb_i, wdata_i} = '0;
        rst_i = 1'b1;
        void'($urandom(83));
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 21'h1fffff : 21'($urandom);
            l = 1'($urandom);
            do_op(2'h0, a, l, i[0], 1'b0, 16'h0000);
            chk(21'(rdata_o), exp_rd(a, i[0], l));
            chk(21'(cyc), 21'(flash_host_pkg::RD_WAIT) + 21'h1);
        end
        m.ident = 1'b1;
        do_op(2'h0, a, 1'b0, 1'b0, 1'b0, 16'h0000);
        chk(21'(rdata_o[7:0]), 21'(m.ID_CODE));
        $display("test reads done");
        for (int i = 0; i < 4; i++) begin
            a = 21'($urandom);
            d = 16'($urandom);
            m.wcnt = 0;
            do_op((i == 0) ? 2'h1 : 2'h2, a, 1'b0, i[0], i[1], d);
            chk(21'(m.wcnt), (i == 0) ? 21'h1 : (i[1] ? 21'h2 : 21'h4));
            chk(m.last_a, a);
            chk(21'(mx), (i == 0) ? 21'h0 : (i[1] ? 21'h1 : 21'h3));
            chk(21'(m.last_d), 21'(i[0] ? {8'h00, d[7:0]} : d));
        end
        $display("test writes done");
        for (int i = 0; i < 2; i++) begin
            m.busy = i[0];
            if (i == 1) begin
                do_op(2'h0, 21'h000000, 1'b0, 1'b0, 1'b0, 16'h0000);
                chk(21'(rdata_o), 21'h000080);
            end
            chk(21'(ready_busy_o), 21'(!i[0]));
            do_op(2'h3, 21'h000000, 1'b0, 1'b0, 1'b0, 16'h0000);
            chk(21'(ab), 21'(i[0]));
            chk(21'(timeout_o), 21'h000000);
            do_op(2'h0, 21'h012345, 1'b0, 1'b0, 1'b0, 16'h0000);
            chk(21'(rdata_o), exp_rd(21'h012345, 1'b0, 1'b0));
        end
        $display("test resets done");
        stop_test();
    end
endmodule
bind flash_host flash_host_checker chk_u (.clk_sys_i, .rst_i, .done_o, .aborted_o, .ce_n_o,
    .oe_n_o, .we_n_o, .reset_n_o, .byte_n_o, .dq_oe_o);
`default_nettype wire
